// file: src/frame_trigger_generator.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module frame_trigger_generator
   import frame_trigger_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire axil_req_t i_axi,
   output axil_rsp_t o_axi,
   input wire logic [N_PORTS-1:0] i_bc_frame_clk,
   input wire logic i_ref_clk,
   input wire logic [N_GPIO-1:0] i_gpio,
   output logic o_trigger
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; third stage only feeds the edge detector
   logic [N_PINS-1:0] pin_raw;
   logic [N_PINS-1:0] sync1_r;
   logic [N_PINS-1:0] sync2_r;
   logic [N_PINS-1:0] sync3_r;
   logic [N_PINS-1:0] pin_rise;

   assign pin_raw = {i_gpio, i_ref_clk, i_bc_frame_clk};

   genvar g;
   generate
      for (g = 0; g < N_PINS; g = g + 1) begin : g_sync
         always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
               sync1_r[g] <= 1'b0;
               sync2_r[g] <= 1'b0;
               sync3_r[g] <= 1'b0;
            end else if (i_ce) begin
               sync1_r[g] <= pin_raw[g];
               sync2_r[g] <= sync1_r[g];
               sync3_r[g] <= sync2_r[g];
            end
         end
         assign pin_rise[g] = sync2_r[g] & ~sync3_r[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic run_r;
   logic style_r;
   logic init_r;
   logic [SRC_W-1:0] src_r;
   logic edge_r;
   logic [REG_W-1:0] high_upper_r;
   logic [REG_W-1:0] high_lower_r;
   logic [REG_W-1:0] low_upper_r;
   logic [REG_W-1:0] low_lower_r;
   logic os_pend_r;
   logic os_active_r;
   trig_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic level_r;
   logic trigger_r;

   // AXI slave state
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic [IDX_W-1:0] wr_idx_r;
   logic [REG_W-1:0] wr_byte_r;
   logic wr_strb_r;
   logic wr_do;
   logic wr_os;
   logic [IDX_W-1:0] rd_idx;
   logic [REG_W-1:0] rd_byte;
   logic rd_hit;
   logic wr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Timing source selection
   logic tick;
   logic ext_sel;
   logic ext_level;

   always_comb begin
      tick = 1'b0;
      case (src_r[SRC_W-1 -: 2])
         SRC_GRP_PORT: tick = ~src_r[1] & pin_rise[src_r[0]];
         SRC_GRP_REF: tick = pin_rise[PIN_REF];
         default: tick = 1'b0;
      endcase
   end

   assign ext_sel = (src_r[SRC_W-1 -: 2] == SRC_GRP_EXT);
   assign ext_level = sync2_r[PIN_GPIO0 + int'(src_r[1:0])];

   // Duration counts per style
   logic [CNT_W-1:0] high_dur;
   logic [CNT_W-1:0] low_dur;
   logic [CNT_W-1:0] half_dur;

   assign half_dur = {high_lower_r, low_upper_r, low_lower_r};
   assign high_dur = style_r ? half_dur : {8'h00, high_upper_r, high_lower_r};
   assign low_dur = style_r ? half_dur : {8'h00, low_upper_r, low_lower_r};

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   assign wr_do = awready_r == 1'b0 && wready_r == 1'b0 && !bvalid_r;
   assign wr_os = wr_do && wr_strb_r && wr_idx_r == IDX_CTL && wr_byte_r[CTL_ONESHOT_BIT];
   assign wr_hit = wr_idx_r inside {IDX_CTL, IDX_HIGH_UPPER, IDX_HIGH_LOWER,
                                    IDX_LOW_UPPER, IDX_LOW_LOWER, IDX_CONFIG, IDX_STATUS};

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         run_r <= 1'b0;
         style_r <= 1'b0;
         init_r <= 1'b0;
         src_r <= SRC_RESET;
         edge_r <= 1'b0;
         high_upper_r <= REG_RESET;
         high_lower_r <= REG_RESET;
         low_upper_r <= REG_RESET;
         low_lower_r <= REG_RESET;
      end else if (i_ce && wr_do && wr_strb_r) begin
         case (wr_idx_r)
            IDX_CTL: begin
               run_r <= wr_byte_r[CTL_RUN_BIT];
               style_r <= wr_byte_r[CTL_STYLE_BIT];
               init_r <= wr_byte_r[CTL_INIT_BIT];
               src_r <= wr_byte_r[CTL_SRC_LSB +: SRC_W];
            end
            IDX_HIGH_UPPER: high_upper_r <= wr_byte_r;
            IDX_HIGH_LOWER: high_lower_r <= wr_byte_r;
            IDX_LOW_UPPER: low_upper_r <= wr_byte_r;
            IDX_LOW_LOWER: low_lower_r <= wr_byte_r;
            IDX_CONFIG: edge_r <= wr_byte_r[CFG_EDGE_BIT];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Generator sequence
   logic gen_go;
   assign gen_go = run_r | os_active_r;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         level_r <= 1'b0;
         os_pend_r <= 1'b0;
         os_active_r <= 1'b0;
      end else if (i_ce) begin
         // A request seen while busy waits; the new write beats the consume
         if (wr_os) begin
            os_pend_r <= 1'b1;
         end else if (state_r == ST_IDLE && !run_r) begin
            os_pend_r <= 1'b0;
         end
         case (state_r)
            ST_IDLE: begin
               cnt_r <= '0;
               level_r <= init_r;
               if (run_r && !ext_sel) begin
                  state_r <= init_r ? ST_HIGH : ST_LOW;
                  cnt_r <= init_r ? high_dur : low_dur;
                  level_r <= init_r;
               end else if (os_pend_r && !run_r && !ext_sel) begin
                  state_r <= ST_HIGH;
                  cnt_r <= high_dur;
                  level_r <= 1'b1;
                  os_active_r <= 1'b1;
               end
            end
            ST_HIGH: begin
               if (!gen_go) begin
                  state_r <= ST_IDLE;
                  level_r <= init_r;
               end else if (tick && cnt_r == '0) begin
                  state_r <= ST_LOW;
                  cnt_r <= low_dur;
                  level_r <= 1'b0;
               end else if (tick) begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ST_LOW: begin
               if (!gen_go) begin
                  state_r <= ST_IDLE;
                  level_r <= init_r;
               end else if (tick && cnt_r == '0) begin
                  // One-shot waits out its low half before the next may start
                  if (os_active_r || !run_r) begin
                     state_r <= ST_IDLE;
                     os_active_r <= 1'b0;
                     level_r <= init_r;
                  end else begin
                     state_r <= ST_HIGH;
                     cnt_r <= high_dur;
                     level_r <= 1'b1;
                  end
               end else if (tick) begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               os_active_r <= 1'b0;
            end
         endcase
      end
   end

   // Output stage; external mode passes the pin only while running
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         trigger_r <= 1'b0;
      end else if (i_ce) begin
         if (ext_sel && run_r) begin
            trigger_r <= ext_level ^ edge_r;
         end else if (ext_sel) begin
            trigger_r <= init_r ^ edge_r;
         end else begin
            trigger_r <= level_r ^ edge_r;
         end
      end
   end

   assign o_trigger = trigger_r;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: capture address and data in any order, then write
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         wr_idx_r <= '0;
         wr_byte_r <= REG_RESET;
         wr_strb_r <= 1'b0;
      end else if (i_ce) begin
         if (awready_r && i_axi.awvalid) begin
            awready_r <= 1'b0;
            wr_idx_r <= i_axi.awaddr[ADDR_W-1:2];
         end
         if (wready_r && i_axi.wvalid) begin
            wready_r <= 1'b0;
            wr_byte_r <= i_axi.wdata[REG_W-1:0];
            wr_strb_r <= i_axi.wstrb[0];
         end
         if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && i_axi.bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   assign rd_idx = i_axi.araddr[ADDR_W-1:2];

   always_comb begin
      rd_byte = REG_RESET;
      rd_hit = 1'b1;
      case (rd_idx)
         // One-shot bit is self-clearing and never reads back
         IDX_CTL: rd_byte = {src_r, 1'b0, init_r, style_r, run_r};
         IDX_HIGH_UPPER: rd_byte = high_upper_r;
         IDX_HIGH_LOWER: rd_byte = high_lower_r;
         IDX_LOW_UPPER: rd_byte = low_upper_r;
         IDX_LOW_LOWER: rd_byte = low_lower_r;
         IDX_CONFIG: rd_byte[CFG_EDGE_BIT] = edge_r;
         IDX_STATUS: begin
            rd_byte[STS_LEVEL_BIT] = trigger_r;
            rd_byte[STS_BUSY_BIT] = (state_r != ST_IDLE);
            rd_byte[STS_PEND_BIT] = os_pend_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (i_ce) begin
         if (arready_r && i_axi.arvalid) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && i_axi.rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign o_axi = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
                    arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   property p_run_starts;
      (i_ce && state_r == ST_IDLE && run_r && !ext_sel) |=> (state_r != ST_IDLE);
   endproperty
   a_run_starts: assert property (p_run_starts) else $error("run did not start");

   property p_split_counts;
      !style_r |-> (high_dur == {8'h00, high_upper_r, high_lower_r})
                   && (low_dur == {8'h00, low_upper_r, low_lower_r});
   endproperty
   a_split_counts: assert property (p_split_counts) else $error("split counts wrong");

   property p_equal_halves;
      style_r |-> (high_dur == low_dur) && (high_dur[7:0] == low_lower_r)
                  && (high_dur[23:16] == high_lower_r);
   endproperty
   a_equal_halves: assert property (p_equal_halves) else $error("halves differ");

   property p_high_upper;
      (i_ce && wr_do && wr_strb_r && wr_idx_r == IDX_HIGH_UPPER && !style_r)
         |=> (high_dur[15:8] == $past(wr_byte_r));
   endproperty
   a_high_upper: assert property (p_high_upper) else $error("high upper byte lost");

   property p_high_count;
      (i_ce && state_r == ST_HIGH && gen_go && tick && cnt_r != '0)
         |=> (state_r == ST_HIGH) && (cnt_r == $past(cnt_r) - 1'b1);
   endproperty
   a_high_count: assert property (p_high_count) else $error("high phase count");

   property p_low_upper;
      (i_ce && wr_do && wr_strb_r && wr_idx_r == IDX_LOW_UPPER && !style_r)
         |=> (low_dur[15:8] == $past(wr_byte_r));
   endproperty
   a_low_upper: assert property (p_low_upper) else $error("low upper byte lost");

   property p_high_to_low;
      (i_ce && state_r == ST_HIGH && gen_go && tick && cnt_r == '0)
         |=> (state_r == ST_LOW) && (cnt_r == $past(low_dur)) && !level_r;
   endproperty
   a_high_to_low: assert property (p_high_to_low) else $error("low phase load");

   property p_one_shot;
      (i_ce && state_r == ST_IDLE && !run_r && os_pend_r && !ext_sel)
         |=> (state_r == ST_HIGH) && os_active_r && level_r;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot not taken");

   property p_init_level;
      (i_ce && state_r == ST_IDLE && run_r && !ext_sel) |=> (level_r == $past(init_r));
   endproperty
   a_init_level: assert property (p_init_level) else $error("start level wrong");

   property p_ext_pass;
      (i_ce && ext_sel && run_r) |=> (o_trigger == ($past(ext_level) ^ $past(edge_r)));
   endproperty
   a_ext_pass: assert property (p_ext_pass) else $error("external pass-through");

   property p_polarity;
      (i_ce && state_r == ST_HIGH && !ext_sel) |=> (o_trigger == !$past(edge_r));
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity wrong");

   property p_idle_hold;
      (i_ce && state_r == ST_IDLE && !run_r && !os_pend_r)
         |=> (state_r == ST_IDLE) && (cnt_r == '0) && (level_r == $past(init_r));
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle not held");

endmodule : frame_trigger_generator

// file: src/frame_trigger_pkg.sv
package frame_trigger_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = ADDR_W - 2;
   localparam int REG_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTL = 10'h018;
   localparam logic [IDX_W-1:0] IDX_HIGH_UPPER = 10'h019;
   localparam logic [IDX_W-1:0] IDX_HIGH_LOWER = 10'h01a;
   localparam logic [IDX_W-1:0] IDX_LOW_UPPER = 10'h01b;
   localparam logic [IDX_W-1:0] IDX_LOW_LOWER = 10'h01c;
   localparam logic [IDX_W-1:0] IDX_CONFIG = 10'h025;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h030;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CTL_RUN_BIT = 0;
   localparam int CTL_STYLE_BIT = 1;
   localparam int CTL_INIT_BIT = 2;
   localparam int CTL_ONESHOT_BIT = 3;
   localparam int CTL_SRC_LSB = 4;
   localparam int SRC_W = 4;
   localparam int CFG_EDGE_BIT = 6;
   localparam int STS_LEVEL_BIT = 0;
   localparam int STS_BUSY_BIT = 1;
   localparam int STS_PEND_BIT = 2;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;
   localparam logic [SRC_W-1:0] SRC_RESET = 4'h0;

   // Timing source groups, upper two bits of the source field
   localparam logic [1:0] SRC_GRP_PORT = 2'h0;
   localparam logic [1:0] SRC_GRP_REF = 2'h1;
   localparam logic [1:0] SRC_GRP_EXT = 2'h2;

   // Pin input vector layout
   localparam int N_PORTS = 2;
   localparam int N_GPIO = 4;
   localparam int PIN_REF = N_PORTS;
   localparam int PIN_GPIO0 = N_PORTS + 1;
   localparam int N_PINS = N_PORTS + 1 + N_GPIO;

   localparam int CNT_W = 24;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HIGH = 3'b010,
      ST_LOW = 3'b100
   } trig_state_t;

endpackage : frame_trigger_pkg

// file: testbench/frame_trigger_generator_test.sv
`timescale 1ns/10ps
module frame_trigger_generator_test;
   import frame_trigger_pkg::*;
   logic i_clk;
   logic i_resetn;
   axil_req_t req;
   axil_rsp_t rsp;
   logic [N_PORTS-1:0] bc_clk;
   logic ref_clk;
   logic [N_GPIO-1:0] gpio;
   logic trig;
   logic prev_trig;
   logic ce;
   logic held;
   logic [31:0] rd;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int rises = 0;
   int r0;
   int per [2] = '{6, 8};

   frame_trigger_generator dut (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ce(ce),
      .i_axi(req),
      .o_axi(rsp),
      .i_bc_frame_clk(bc_clk),
      .i_ref_clk(ref_clk),
      .i_gpio(gpio),
      .o_trigger(trig)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Timing sources derived from the cycle count, so tick spacing is exact
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      ref_clk <= (cycles % 4) < 2;
      bc_clk[0] <= (cycles % 6) < 3;
      bc_clk[1] <= (cycles % 8) < 4;
      prev_trig <= trig;
      if (trig === 1'b1 && prev_trig === 1'b0) rises <= rises + 1;
      if (cycles == 40000) begin
         num_errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task report_and_stop();
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task check_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_word

   task check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask : check_bit

   // Each valid drops at the first edge that sees its ready high, so no strobe is raised twice per step
   task axi_write(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      while (!(aw_done && w_done)) begin
         @(posedge i_clk);
         if (!aw_done && rsp.awready === 1'b1) begin
            aw_done = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (!w_done && rsp.wready === 1'b1) begin
            w_done = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      do @(posedge i_clk); while (rsp.bvalid !== 1'b1);
      check_word({30'h0, rsp.bresp}, {30'h0, er});
   endtask : axi_write

   task axi_read(input logic [IDX_W-1:0] idx, output logic [31:0] d, input logic [1:0] er);
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      do @(posedge i_clk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge i_clk); while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      check_word({30'h0, rsp.rresp}, {30'h0, er});
   endtask : axi_read

   // Lets a partial phase at lvl pass, skips the opposite one, then counts a full phase
   task measure(input logic lvl, input int exp_n);
      int n;
      n = 0;
      while (trig === lvl && n < 3000) begin
         @(posedge i_clk);
         n++;
      end
      n = 0;
      while (trig !== lvl && n < 3000) begin
         @(posedge i_clk);
         n++;
      end
      n = 0;
      while (trig === lvl && n < 3000) begin
         @(posedge i_clk);
         n++;
      end
      check_word(32'(n), 32'(exp_n));
   endtask : measure

   task set_counts(input logic [7:0] a, b, c, e);
      axi_write(IDX_HIGH_UPPER, a, RESP_OKAY);
      axi_write(IDX_HIGH_LOWER, b, RESP_OKAY);
      axi_write(IDX_LOW_UPPER, c, RESP_OKAY);
      axi_write(IDX_LOW_LOWER, e, RESP_OKAY);
   endtask : set_counts

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_resetn = 1'b0;
      ce = 1'b1;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      gpio = '0;
      ref_clk = 1'b0;
      bc_clk = '0;
      prev_trig = 1'b0;
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      for (int i = 0; i < 5; i++) begin
         axi_read(IDX_W'(IDX_CTL + i), rd, RESP_OKAY);
         check_word(rd, 32'h0);
      end
      axi_read(IDX_CONFIG, rd, RESP_OKAY);
      check_word(rd, 32'h0);
      axi_read(10'h3ff, rd, RESP_SLVERR);
      check_word(rd, 32'h0);
      axi_write(10'h3ff, 8'h5a, RESP_SLVERR);
      set_counts(8'ha5, 8'h3c, 8'hc3, 8'h5a);
      for (int i = 0; i < 4; i++) begin
         axi_read(IDX_W'(IDX_HIGH_UPPER + i), rd, RESP_OKAY);
         check_word(rd, {24'h0, (i[0] ^ i[1]) ? 8'h3c ^ {8{i[1]}} : 8'ha5 ^ {8{i[1]}}});
      end
      $display("Test registers done");
      // Independent style, local reference: high 0x0100, low 0x0002
      set_counts(8'h01, 8'h00, 8'h00, 8'h02);
      axi_write(IDX_CTL, 8'h41, RESP_OKAY);
      measure(1'b1, 257 * 4);
      measure(1'b0, 3 * 4);
      // Equal halves: {0x00,0x01,0x03}, upper high byte ignored
      set_counts(8'hff, 8'h00, 8'h01, 8'h03);
      axi_write(IDX_CTL, 8'h43, RESP_OKAY);
      measure(1'b1, 260 * 4);
      measure(1'b0, 260 * 4);
      axi_write(IDX_CTL, 8'h00, RESP_OKAY);
      $display("Test period styles done");
      set_counts(8'h00, 8'h00, 8'h00, 8'h01);
      for (int p = 0; p < 2; p++) begin
         axi_write(IDX_CTL, {p[3:0], 4'h1}, RESP_OKAY);
         measure(1'b1, per[p]);
         measure(1'b0, 2 * per[p]);
      end
      // Clock enable low must freeze the running generator mid-phase
      ce <= 1'b0;
      @(posedge i_clk);
      held = trig;
      repeat (40) @(posedge i_clk);
      check_bit(trig, held);
      ce <= 1'b1;
      $display("Test port sources done");
      axi_write(IDX_CTL, 8'h44, RESP_OKAY);
      // Let the stop and the new idle level settle before counting edges
      repeat (5) @(posedge i_clk);
      r0 = rises;
      repeat (100) @(posedge i_clk);
      check_bit(trig, 1'b1);
      check_word(32'(rises - r0), 32'h0);
      axi_read(IDX_STATUS, rd, RESP_OKAY);
      check_word(rd, 32'h1);
      axi_write(IDX_CONFIG, 8'h40, RESP_OKAY);
      repeat (5) @(posedge i_clk);
      check_bit(trig, 1'b0);
      axi_write(IDX_CTL, 8'h40, RESP_OKAY);
      repeat (5) @(posedge i_clk);
      check_bit(trig, 1'b1);
      axi_write(IDX_CONFIG, 8'h00, RESP_OKAY);
      repeat (5) @(posedge i_clk);
      check_bit(trig, 1'b0);
      $display("Test idle and polarity done");
      // One-shot with run low: exactly one pulse, bit reads back 0
      set_counts(8'h00, 8'h01, 8'h00, 8'h00);
      r0 = rises;
      axi_write(IDX_CTL, 8'h48, RESP_OKAY);
      // Request already taken: busy, nothing pending, output not yet high
      axi_read(IDX_STATUS, rd, RESP_OKAY);
      check_word(rd, 32'h2);
      repeat (200) @(posedge i_clk);
      check_word(32'(rises - r0), 32'h1);
      check_bit(trig, 1'b0);
      axi_read(IDX_CTL, rd, RESP_OKAY);
      check_word(rd, 32'h40);
      $display("Test one-shot done");
      for (int g = 0; g < 4; g++) begin
         gpio <= 4'h1 << g;
         axi_write(IDX_CTL, {2'b10, g[1:0], 4'h1}, RESP_OKAY);
         repeat (6) @(posedge i_clk);
         check_bit(trig, 1'b1);
         gpio <= ~(4'h1 << g);
         repeat (6) @(posedge i_clk);
         check_bit(trig, 1'b0);
      end
      axi_write(IDX_CTL, 8'h21, RESP_OKAY);
      r0 = rises;
      repeat (100) @(posedge i_clk);
      check_word(32'(rises - r0), 32'h0);
      $display("Test external and reserved sources done");
      report_and_stop();
   end
endmodule : frame_trigger_generator_test
